/* core/mda_pkg.sv */
// Package: constants for the core's data memory access logic
package mda_pkg;
  // Special function addresses of the block's registers
  localparam logic [7:0] SFR_PTR0_LO = 8'h82;
  localparam logic [7:0] SFR_PTR0_HI = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI = 8'h85;
  localparam logic [7:0] SFR_STRETCH_CONTROL = 8'h8E;
  localparam logic [7:0] SFR_POINTER_SELECT = 8'h92;
  localparam logic [7:0] SFR_PAGE_HIGH_ADDRESS = 8'hBF;
  localparam logic [7:0] SFR_PROGRAM_STATUS_WORD = 8'hD0;
  // Reset values
  localparam logic [7:0] STRETCH_CONTROL_RESET = 8'h01;
  localparam logic [7:0] POINTER_SELECT_RESET = 8'h00;
  localparam logic [7:0] PAGE_HIGH_RESET = 8'h00;
  // Field positions
  localparam int STRETCH_MSB = 2;
  localparam int SELECT_BIT = 0;
  localparam int BANK_LSB = 3;
  // Program space
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_STEP_LOG2 = 3;
  // Internal space layout
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  // External data ranges
  localparam logic [15:0] DRAM_LAST = 16'h07FF;
  localparam logic [15:0] CE_DATA_FIRST = 16'h1000;
  localparam logic [15:0] CE_DATA_LAST = 16'h13FF;
  localparam logic [15:0] IO_FIRST = 16'h2000;
  localparam logic [15:0] IO_LAST = 16'h20FF;
  localparam logic [15:0] CE_PROG_FIRST = 16'h3000;
  localparam logic [15:0] CE_PROG_LAST = 16'h3FFF;
  localparam int RAM_AW = 11;
  // External move kinds
  typedef enum logic [1:0] {
    MDA_MOVE_NONE,
    MDA_MOVE_READ,
    MDA_MOVE_WRITE
  } mda_move_t;
  // Strobe sequencer states
  typedef enum logic [1:0] {
    MDA_IDLE,
    MDA_RD,
    MDA_WR_ADDR,
    MDA_WR_STB
  } mda_state_t;
endpackage

/* core/mda_ram.sv */
// Small synchronous data RAM with registered read data
`timescale 1ns/1ps
module mda_ram (
  // Clock
  input wire logic mclk,
  // Access port
  input wire logic we,
  input wire logic [10:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:2047];

  // Write, and registered read of the word held before the write
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // mda_ram

/* core/mda_decode.sv */
// Internal space and program vector decoding
`timescale 1ns/1ps
module mda_decode (
  // Internal access
  input wire logic [7:0] int_addr,
  input wire logic int_indirect,
  input wire logic [1:0] bank_sel,
  input wire logic [2:0] vector_num,
  // Decoded results
  output logic int_is_sfr,
  output logic int_is_bank_reg,
  output logic int_is_bit_area,
  output logic [7:0] bank_base,
  output logic [15:0] vector_addr
);
  // Direct upper half reaches the special function space
  assign int_is_sfr = int_addr[7] & ~int_indirect;
  assign int_is_bank_reg = int_addr < mda_pkg::BIT_AREA_BASE;
  assign int_is_bit_area = int_addr[7:4] == 4'h2;
  assign bank_base = {3'h0, bank_sel, 3'h0};
  // Vectors spaced eight bytes apart
  assign vector_addr = mda_pkg::VECTOR_BASE +
    {10'h000, vector_num, 3'h0};
endmodule // mda_decode

/* core/mda_core.sv */
// External data access, pointers, stretch strobes and space decode
`timescale 1ns/1ps
module mda_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Special function register port from execution
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Pointer operations
  input wire logic ptr_load16,
  input wire logic [15:0] ptr_load_value,
  input wire logic ptr_inc,
  // External move request
  input wire logic move_req,
  input wire logic move_to_acc,
  input wire logic move_paged,
  input wire logic [7:0] work_reg_value,
  input wire logic [7:0] acc_value,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  // Program fetch
  input wire logic fetch_req,
  input wire logic code_read_req,
  input wire logic [15:0] code_addr,
  output logic prog_rd,
  output logic [15:0] prog_addr,
  // Internal space decode
  input wire logic [7:0] int_addr,
  input wire logic int_indirect,
  input wire logic [2:0] vector_num,
  output logic int_is_sfr,
  output logic int_is_bank_reg,
  output logic int_is_bit_area,
  output logic [7:0] work_reg_addr,
  output logic [15:0] vector_addr,
  // External memory interface
  output logic [15:0] mem_addr,
  output logic mem_addr_valid,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [1:0] mem_sel,
  input wire logic [7:0] ce_data_rdata,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] ce_prog_rdata
);
  logic [7:0] stretch_control_reg;
  logic [7:0] pointer_select_reg;
  logic [7:0] page_high_address_reg;
  logic [7:0] psw_reg;
  logic [15:0] primary_data_pointer_reg;
  logic [15:0] secondary_data_pointer_reg;
  logic [15:0] active_ptr;
  logic [2:0] stretch;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  mda_pkg::mda_state_t state_reg;
  mda_pkg::mda_state_t state_next;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [15:0] pc_reg;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] bank_base;
  logic start;
  logic [15:0] move_addr;
  logic [mda_pkg::RAM_AW-1:0] ram_addr;

  // Decode of a backed external address region
  // Select 3 also covers the unbacked holes; backed() splits them
  function automatic logic [1:0] region(input logic [15:0] a);
    if (a <= mda_pkg::DRAM_LAST) begin
      region = 2'h0;
    end else if (a >= mda_pkg::CE_DATA_FIRST &&
                 a <= mda_pkg::CE_DATA_LAST) begin
      region = 2'h1;
    end else if (a >= mda_pkg::IO_FIRST && a <= mda_pkg::IO_LAST) begin
      region = 2'h2;
    end else begin
      region = 2'h3;
    end
  endfunction

  // True where physical memory answers
  function automatic logic backed(input logic [15:0] a);
    backed = region(a) != 2'h3 ||
      (a >= mda_pkg::CE_PROG_FIRST && a <= mda_pkg::CE_PROG_LAST);
  endfunction

  // Register write strobe aimed at one address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = sfr_wr && a == r;
  endfunction

  assign stretch = stretch_control_reg[mda_pkg::STRETCH_MSB:0];
  // Select bit steers moves, loads and increments; byte register writes go by address
  assign active_ptr = pointer_select_reg[mda_pkg::SELECT_BIT] ?
    secondary_data_pointer_reg : primary_data_pointer_reg;
  // Requests during the write tail are refused, not queued
  assign start = move_req && !move_busy;
  // Address of the move being asked for; captured on start
  assign move_addr = move_paged ?
    {page_high_address_reg, work_reg_value} : active_ptr;

  // Stretch, select, page and status word registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stretch_control_reg <= mda_pkg::STRETCH_CONTROL_RESET;
      pointer_select_reg <= mda_pkg::POINTER_SELECT_RESET;
      page_high_address_reg <= mda_pkg::PAGE_HIGH_RESET;
      psw_reg <= 8'h00;
    end else begin
      if (hit(sfr_addr, mda_pkg::SFR_STRETCH_CONTROL)) begin
        stretch_control_reg <= sfr_wdata;
      end
      if (hit(sfr_addr, mda_pkg::SFR_POINTER_SELECT)) begin
        pointer_select_reg <= sfr_wdata;
      end
      if (hit(sfr_addr, mda_pkg::SFR_PAGE_HIGH_ADDRESS)) begin
        page_high_address_reg <= sfr_wdata;
      end
      if (hit(sfr_addr, mda_pkg::SFR_PROGRAM_STATUS_WORD)) begin
        psw_reg <= sfr_wdata;
      end
    end
  end

  // Primary pointer: loads and increments only when selected
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      primary_data_pointer_reg <= 16'h0000;
    end else if (!pointer_select_reg[mda_pkg::SELECT_BIT]) begin
      if (ptr_load16) begin
        primary_data_pointer_reg <= ptr_load_value;
      end else if (ptr_inc) begin
        primary_data_pointer_reg <= primary_data_pointer_reg + 16'h0001;
      end
    end else if (hit(sfr_addr, mda_pkg::SFR_PTR0_LO)) begin
      primary_data_pointer_reg[7:0] <= sfr_wdata;
    end else if (hit(sfr_addr, mda_pkg::SFR_PTR0_HI)) begin
      primary_data_pointer_reg[15:8] <= sfr_wdata;
    end
    if (rst_n && !pointer_select_reg[mda_pkg::SELECT_BIT] &&
        !ptr_load16 && !ptr_inc) begin
      if (hit(sfr_addr, mda_pkg::SFR_PTR0_LO)) begin
        primary_data_pointer_reg[7:0] <= sfr_wdata;
      end
      if (hit(sfr_addr, mda_pkg::SFR_PTR0_HI)) begin
        primary_data_pointer_reg[15:8] <= sfr_wdata;
      end
    end
  end

  // Secondary pointer: same, under the other select value
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      secondary_data_pointer_reg <= 16'h0000;
    end else if (pointer_select_reg[mda_pkg::SELECT_BIT] &&
                 (ptr_load16 || ptr_inc)) begin
      if (ptr_load16) begin
        secondary_data_pointer_reg <= ptr_load_value;
      end else begin
        secondary_data_pointer_reg <= secondary_data_pointer_reg +
          16'h0001;
      end
    end else begin
      if (hit(sfr_addr, mda_pkg::SFR_PTR1_LO)) begin
        secondary_data_pointer_reg[7:0] <= sfr_wdata;
      end
      if (hit(sfr_addr, mda_pkg::SFR_PTR1_HI)) begin
        secondary_data_pointer_reg[15:8] <= sfr_wdata;
      end
    end
  end

  // Register read-back
  always_comb begin
    unique case (sfr_addr)
      mda_pkg::SFR_PTR0_LO: sfr_rdata = primary_data_pointer_reg[7:0];
      mda_pkg::SFR_PTR0_HI: sfr_rdata = primary_data_pointer_reg[15:8];
      mda_pkg::SFR_PTR1_LO: sfr_rdata = secondary_data_pointer_reg[7:0];
      mda_pkg::SFR_PTR1_HI: sfr_rdata = secondary_data_pointer_reg[15:8];
      mda_pkg::SFR_STRETCH_CONTROL: sfr_rdata = stretch_control_reg;
      mda_pkg::SFR_POINTER_SELECT: sfr_rdata = pointer_select_reg;
      mda_pkg::SFR_PAGE_HIGH_ADDRESS: sfr_rdata = page_high_address_reg;
      mda_pkg::SFR_PROGRAM_STATUS_WORD: sfr_rdata = psw_reg;
      default: sfr_rdata = 8'h00;
    endcase
  end

  // Strobe width sequencer; count holds clocks left in the strobe phase after this one
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    unique case (state_reg)
      mda_pkg::MDA_IDLE: begin
        if (start) begin
          count_next = {1'b0, stretch};
          if (move_to_acc) begin
            state_next = mda_pkg::MDA_RD;
          end else begin
            state_next = mda_pkg::MDA_WR_ADDR;
          end
        end
      end
      mda_pkg::MDA_RD: begin
        // Read strobe runs s+1 clocks, counting s down to zero
        if (count_reg == 4'h0) begin
          state_next = mda_pkg::MDA_IDLE;
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
      mda_pkg::MDA_WR_ADDR: begin
        // One leading address clock before the write strobe
        state_next = mda_pkg::MDA_WR_STB;
        count_next = (stretch == 3'h0) ? 4'h0 :
          {1'b0, stretch} - 4'h1;
      end
      mda_pkg::MDA_WR_STB: begin
        if (count_reg == 4'h0) begin
          state_next = mda_pkg::MDA_IDLE;
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= mda_pkg::MDA_IDLE;
      count_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Address capture at move start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (start) begin
      wdata_reg <= acc_value;
      addr_reg <= move_addr;
    end
  end

  // Write phase trails one clock past the strobe when stretch is nonzero (s+2 address)
  logic wr_tail_reg;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_tail_reg <= 1'b0;
    end else begin
      wr_tail_reg <= state_reg == mda_pkg::MDA_WR_STB &&
        count_reg == 4'h0 && stretch != 3'h0;
    end
  end

  // Strobes decode straight from state, no extra register delay
  assign mem_rd = state_reg == mda_pkg::MDA_RD;
  assign mem_wr = state_reg == mda_pkg::MDA_WR_STB;
  assign mem_addr_valid = mem_rd || mem_wr ||
    state_reg == mda_pkg::MDA_WR_ADDR || wr_tail_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_sel = region(addr_reg);
  // Busy covers the write tail so the address holds through it
  assign move_busy = state_reg != mda_pkg::MDA_IDLE || wr_tail_reg;
  // Unbacked writes are simply dropped
  assign ram_we = mem_wr && count_reg == 4'h0 &&
    region(addr_reg) == 2'h0;

  // Read ahead on the start edge so that a zero-stretch read,
  // which has only one strobe clock, still sees its own word
  assign ram_addr = start ? move_addr[mda_pkg::RAM_AW-1:0] :
    addr_reg[mda_pkg::RAM_AW-1:0];

  mda_ram u_ram (
    .mclk(mclk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(wdata_reg),
    .rdata(ram_rdata)
  );

  // Read data return and completion pulse
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      move_done <= 1'b0;
      move_rdata <= 8'h00;
    end else begin
      move_done <= (mem_rd || mem_wr) && count_reg == 4'h0;
      if (mem_rd && count_reg == 4'h0) begin
        unique case (region(addr_reg))
          2'h0: move_rdata <= ram_rdata;
          2'h1: move_rdata <= ce_data_rdata;
          2'h2: move_rdata <= io_rdata;
          // Unbacked reads give zero rather than stale data
          2'h3: move_rdata <= backed(addr_reg) ? ce_prog_rdata :
            8'h00;
        endcase
      end
    end
  end

  // Program counter starts at the reset vector
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pc_reg <= mda_pkg::RESET_VECTOR;
    end else if (fetch_req) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end

  // Program reads only for fetches and code reads
  assign prog_rd = fetch_req || code_read_req;
  assign prog_addr = code_read_req ? code_addr : pc_reg;

  mda_decode u_decode (
    .int_addr(int_addr),
    .int_indirect(int_indirect),
    .bank_sel(psw_reg[mda_pkg::BANK_LSB+1:mda_pkg::BANK_LSB]),
    .vector_num(vector_num),
    .int_is_sfr(int_is_sfr),
    .int_is_bank_reg(int_is_bank_reg),
    .int_is_bit_area(int_is_bit_area),
    .bank_base(bank_base),
    .vector_addr(vector_addr)
  );

  // Working register 0 address of the active bank
  assign work_reg_addr = bank_base;
endmodule // mda_core

/* testbench/mda_core_properties.sv */
// Checker: strobe widths, addressing and decode of the access block
`timescale 1ns/1ps
module mda_core_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register and move requests
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic move_req,
  input wire logic move_to_acc,
  input wire logic move_paged,
  input wire logic [7:0] work_reg_value,
  input wire logic move_busy,
  input wire logic move_done,
  // Memory side
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  // Decode
  input wire logic [7:0] int_addr,
  input wire logic int_indirect,
  input wire logic int_is_sfr,
  input wire logic int_is_bit_area,
  input wire logic [2:0] vector_num,
  input wire logic [15:0] vector_addr
);
  logic [2:0] str_reg;
  logic [7:0] page_reg;
  logic [3:0] rd_cnt;
  logic [3:0] wr_cnt;
  logic take;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign take = move_req && !move_busy;
  // Shadow copies of stretch and page settings
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      str_reg <= 3'h1;
      page_reg <= 8'h00;
    end else if (sfr_wr && sfr_addr == 8'h8E) begin
      str_reg <= sfr_wdata[2:0];
    end else if (sfr_wr && sfr_addr == 8'hBF) begin
      page_reg <= sfr_wdata;
    end
  end
  // Run lengths; judged on the cycle after a run ends
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_cnt <= 4'h0;
      wr_cnt <= 4'h0;
    end else begin
      rd_cnt <= mem_rd ? rd_cnt + 4'h1 : 4'h0;
      wr_cnt <= mem_wr ? wr_cnt + 4'h1 : 4'h0;
    end
  end
  a_read_start: assert property (
    take && move_to_acc |=> mem_rd && !mem_wr)
    else $error("read move did not raise read strobe");
  a_write_start: assert property (
    take && !move_to_acc |=> !mem_rd ##1 mem_wr)
    else $error("write move strobe order wrong");
  a_read_width: assert property (
    !mem_rd && rd_cnt != 4'h0 |-> rd_cnt == {1'h0, str_reg} + 4'h1)
    else $error("read strobe width wrong");
  a_write_width: assert property (
    !mem_wr && wr_cnt != 4'h0 |->
    wr_cnt == ((str_reg == 3'h0) ? 4'h1 : {1'h0, str_reg}))
    else $error("write strobe width wrong");
  a_done_after_rd: assert property ($fell(mem_rd) |-> move_done)
    else $error("read move did not complete");
  a_paged_addr: assert property (
    take && move_paged |=> mem_addr == {page_reg, $past(work_reg_value)})
    else $error("paged address wrong");
  a_addr_hold: assert property (
    move_busy && $past(move_busy) |-> $stable(mem_addr))
    else $error("address moved during an access");
  a_sfr_direct: assert property (
    int_is_sfr == (int_addr[7] && !int_indirect))
    else $error("special space decode wrong");
  a_bit_area: assert property (
    int_is_bit_area == (int_addr[7:4] == 4'h2))
    else $error("bit area decode wrong");
  a_vector_step: assert property (
    vector_addr == 16'h0003 + {10'h000, vector_num, 3'h0})
    else $error("vector address wrong");
endmodule // mda_core_properties

/* testbench/mda_mem_model.sv */
// Behavioural model of the peripheral memories beside the block
`timescale 1ns/1ps
module mda_mem_model (
  // Clock
  input wire logic mclk,
  // Memory side of the block
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [1:0] mem_sel,
  output logic [7:0] ce_data_rdata,
  output logic [7:0] io_rdata,
  output logic [7:0] ce_prog_rdata
);
  logic [7:0] mem [0:3][0:255];
  logic [7:0] a;
  assign a = mem_addr[7:0];
  // Only backed ranges keep data; select 3 is also unbacked space
  always @(posedge mclk) begin
    if (mem_wr && mem_sel != 2'h0 &&
        (mem_sel != 2'h3 || mem_addr[15:12] == 4'h3)) begin
      mem[mem_sel][a] <= mem_wdata;
    end
  end
  // Unselected outputs show inverted data, never the held value
  assign ce_data_rdata = (mem_rd && mem_sel == 2'h1) ? mem[1][a] : ~mem[1][a];
  assign io_rdata = (mem_rd && mem_sel == 2'h2) ? mem[2][a] : ~mem[2][a];
  assign ce_prog_rdata = (mem_rd && mem_sel == 2'h3) ? mem[3][a] : ~mem[3][a];
endmodule // mda_mem_model

/* testbench/mda_core_bench.sv */
// Self-checking bench for the data memory access block
`timescale 1ns/1ps
module mda_core_bench;
  logic mclk = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, ptr_load16 = 1'h0;
  logic ptr_inc = 1'h0, move_req = 1'h0, move_to_acc = 1'h0;
  logic move_paged = 1'h0, fetch_req = 1'h0, code_read_req = 1'h0;
  logic int_indirect = 1'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, int_addr = 8'h00;
  logic [7:0] work_reg_value = 8'h00, acc_value = 8'h00;
  logic [15:0] ptr_load_value = 16'h0000, code_addr = 16'h0000;
  logic [2:0] vector_num = 3'h0;
  logic move_busy, move_done, prog_rd, int_is_sfr, int_is_bank_reg;
  logic int_is_bit_area, mem_addr_valid, mem_rd, mem_wr;
  logic [7:0] sfr_rdata, move_rdata, work_reg_addr, mem_wdata;
  logic [7:0] ce_data_rdata, io_rdata, ce_prog_rdata, rd;
  logic [15:0] prog_addr, vector_addr, mem_addr, seen;
  logic [1:0] mem_sel;
  int error_cnt = 0, n_checks = 0, rc, wc, vc;
  mda_core u_dut (.mclk, .rst_n, .sfr_wr, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .ptr_load16, .ptr_load_value, .ptr_inc, .move_req,
    .move_to_acc, .move_paged, .work_reg_value, .acc_value, .move_busy,
    .move_done, .move_rdata, .fetch_req, .code_read_req, .code_addr,
    .prog_rd, .prog_addr, .int_addr, .int_indirect, .vector_num,
    .int_is_sfr, .int_is_bank_reg, .int_is_bit_area, .work_reg_addr,
    .vector_addr, .mem_addr, .mem_addr_valid, .mem_rd, .mem_wr,
    .mem_wdata, .mem_sel, .ce_data_rdata, .io_rdata, .ce_prog_rdata);
  mda_mem_model u_mem (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .mem_sel, .ce_data_rdata, .io_rdata, .ce_prog_rdata);
  // Clock at 250 MHz
  always #2 mclk = ~mclk;
  task automatic chk(input string nm, input logic [15:0] e, got);
    n_checks++;
    if (got !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, got);
      error_cnt++;
    end
  endtask
  task automatic sfr_w(input logic [7:0] a, d);
    @(posedge mclk);
    sfr_wr <= 1'h1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'h0;
  endtask
  task automatic sfr_r(input logic [7:0] a);
    @(posedge mclk);
    sfr_addr <= a;
    @(negedge mclk);
    rd = sfr_rdata;
  endtask
  task automatic ld(input logic [15:0] v, input logic inc);
    @(posedge mclk);
    ptr_load16 <= 1'h1;
    ptr_load_value <= v;
    @(posedge mclk);
    ptr_load16 <= 1'h0;
    ptr_inc <= inc;
    @(posedge mclk);
    ptr_inc <= 1'h0;
  endtask
  // One move; counts strobe cycles until done, bounded
  task automatic mv(input logic r, pg, input logic [7:0] w, acc);
    @(posedge mclk);
    move_req <= 1'h1;
    move_to_acc <= r;
    move_paged <= pg;
    work_reg_value <= w;
    acc_value <= acc;
    @(posedge mclk);
    move_req <= 1'h0;
    rc = 0;
    wc = 0;
    vc = 0;
    for (int i = 0; i < 24; i++) begin
      @(negedge mclk);
      if (mem_rd === 1'h1) rc++;
      if (mem_wr === 1'h1) wc++;
      if (mem_addr_valid === 1'h1) vc++;
      if (mem_rd === 1'h1 || mem_wr === 1'h1) seen = mem_addr;
      if (mem_wr === 1'h1) chk("wdata", 16'(acc), 16'(mem_wdata));
      if (move_done === 1'h1) break;
    end
    rd = move_rdata;
    chk("done", 16'h0001, {15'h0000, move_done});
  endtask
  task automatic t_reset;
    sfr_r(8'h8E);
    chk("stretch", 16'h0001, {8'h00, rd});
    sfr_r(8'h92);
    chk("select", 16'h0000, {8'h00, rd});
    sfr_r(8'hBF);
    chk("page", 16'h0000, {8'h00, rd});
    chk("pc", 16'h0000, prog_addr);
    $display("reset test done");
  endtask
  task automatic t_widths;
    for (int s = 0; s < 8; s++) begin
      sfr_w(8'h8E, 8'hF8 | 8'(s));
      ld(16'h1000 + 16'(s), 1'h0);
      mv(1'h0, 1'h0, 8'h00, 8'hA0 + 8'(s));
      chk("wr width", (s == 0) ? 16'h1 : 16'(s), 16'(wc));
      chk("wr addr", 16'h1000 + 16'(s), seen);
      chk("wr valid", (s == 0) ? 16'h2 : 16'(s + 2), 16'(vc));
      mv(1'h1, 1'h0, 8'h00, 8'h00);
      chk("rd width", 16'(s + 1), 16'(rc));
      chk("rd valid", 16'(s + 1), 16'(vc));
      chk("rd data", 16'h00A0 + 16'(s), {8'h00, rd});
    end
    sfr_w(8'h8E, 8'h01);
    $display("stretch test done");
  endtask
  // Paged round trip at an ordinary and a last-byte page
  task automatic t_paged;
    logic [7:0] pg [2] = '{8'h20, 8'h3F};
    logic [7:0] lo [2] = '{8'h05, 8'hFF};
    for (int k = 0; k < 2; k++) begin
      sfr_w(8'hBF, pg[k]);
      mv(1'h0, 1'h1, lo[k], 8'h5A + 8'(k));
      chk("paged addr", {pg[k], lo[k]}, seen);
      mv(1'h1, 1'h1, lo[k], 8'h00);
      chk("paged data", 16'h005A + 16'(k), {8'h00, rd});
    end
    $display("paged test done");
  endtask
  task automatic t_pointers;
    sfr_w(8'h92, 8'h01);
    ld(16'h3000, 1'h1);
    sfr_r(8'h84);
    chk("ptr1 lo", 16'h0001, {8'h00, rd});
    sfr_r(8'h85);
    chk("ptr1 hi", 16'h0030, {8'h00, rd});
    sfr_r(8'h82);
    chk("ptr0 lo", 16'h0007, {8'h00, rd});
    mv(1'h0, 1'h0, 8'h00, 8'h66);
    chk("ptr1 addr", 16'h3001, seen);
    sfr_w(8'h92, 8'h00);
    mv(1'h1, 1'h0, 8'h00, 8'h00);
    chk("ptr0 addr", 16'h1007, seen);
    chk("ptr0 data", 16'h00A7, {8'h00, rd});
    $display("pointer test done");
  endtask
  task automatic t_unbacked;
    logic [15:0] ad [2] = '{16'h0800, 16'h07FF};
    logic [7:0] ex [2] = '{8'h00, 8'h44};
    // Zero stretch so the one-clock RAM read is exercised
    sfr_w(8'h8E, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ld(ad[k], 1'h0);
      mv(1'h0, 1'h0, 8'h00, 8'h44);
      mv(1'h1, 1'h0, 8'h00, 8'h00);
      chk("ram edge", {8'h00, ex[k]}, {8'h00, rd});
    end
    sfr_w(8'h8E, 8'h01);
    $display("range test done");
  endtask
  task automatic t_decode;
    logic [7:0] ia [5] = '{8'h1F, 8'h20, 8'h2F, 8'h30, 8'h80};
    logic [15:0] pcx = 16'h0000;
    for (int b = 0; b < 4; b++) begin
      sfr_w(8'hD0, 8'(b << 3));
      @(negedge mclk);
      chk("bank", 16'(b * 8), {8'h00, work_reg_addr});
    end
    for (int k = 0; k < 10; k++) begin
      @(posedge mclk);
      int_addr <= ia[k / 2];
      int_indirect <= k[0];
      vector_num <= 3'(k);
      fetch_req <= k[1];
      code_read_req <= k[2];
      code_addr <= 16'h4A5B + 16'(k);
      @(negedge mclk);
      chk("sfr", {15'h0, ia[k / 2][7] & ~k[0]}, {15'h0, int_is_sfr});
      chk("bank reg", 16'(ia[k / 2] < 8'h20), 16'(int_is_bank_reg));
      chk("vector", 16'h0003 + 16'((k % 8) * 8), vector_addr);
      chk("prog rd", {15'h0, k[1] | k[2]}, {15'h0, prog_rd});
      chk("prog addr", k[2] ? 16'h4A5B + 16'(k) : pcx, prog_addr);
      if (k[1]) pcx++;
    end
    $display("decode test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset for 6 cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset();
    t_widths();
    t_paged();
    t_pointers();
    t_unbacked();
    t_decode();
    wrap_up();
  end
  // Scenarios need well under 2000 cycles; allow 25000
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule // mda_core_bench
bind mda_core mda_core_properties u_props (.mclk, .rst_n, .sfr_wr,
  .sfr_addr, .sfr_wdata, .move_req, .move_to_acc, .move_paged,
  .work_reg_value, .move_busy, .move_done, .mem_addr, .mem_rd, .mem_wr,
  .int_addr, .int_indirect, .int_is_sfr, .int_is_bit_area, .vector_num,
  .vector_addr);
